// >>> drd_pkg.sv
package drd_pkg;

  // core clock
  localparam int unsigned CLK_PERIOD_NS = 40;

  // acknowledgement latency: time from first unacknowledged good packet to a forced ack
  localparam int unsigned ACK_LAT_NS    = 4000;
  localparam int unsigned ACK_LAT_CYC   = (ACK_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          LAT_W         = 8;
  localparam logic [LAT_W-1:0] LAT_LAST = LAT_W'(ACK_LAT_CYC - 1);
  localparam logic [LAT_W-1:0] LAT_RST  = 8'h00;

  // sequence numbers
  localparam int          SEQ_W         = 12;
  localparam logic [SEQ_W-1:0] SEQ_RST  = 12'h000;
  localparam logic [SEQ_W-1:0] SEQ_ONE  = 12'h001;
  localparam logic [SEQ_W-1:0] SEQ_HALF = 12'h800;

  // retry buffer occupancy
  localparam int          RCNT_W        = 12;
  localparam logic [RCNT_W-1:0] RCNT_RST = 12'h000;
  localparam logic [RCNT_W-1:0] RCNT_MAX = 12'hFFF;
  localparam logic [4:0]  RCNT_SAT      = 5'h1F;

  // test-output slice positions
  localparam int TO_LSB        = 296;
  localparam int TO_MSB        = 319;
  localparam int BIT_LAT_RUN   = 296;
  localparam int BIT_LAT_EXP   = 297;
  localparam int BIT_AN_REQ    = 298;
  localparam int BIT_AN_NAK    = 299;
  localparam int BIT_PM_RX     = 300;
  localparam int BIT_FC_RX     = 301;
  localparam int FC_KIND_LSB   = 302;
  localparam int FC_KIND_MSB   = 305;
  localparam int FC_CHAN_LSB   = 306;
  localparam int FC_CHAN_MSB   = 308;
  localparam int BIT_TLP_NULL  = 309;
  localparam int BIT_TLP_CRC   = 310;
  localparam int BIT_TLP_VALID = 311;
  localparam int BIT_TLP_DUP   = 312;
  localparam int BIT_TLP_OOS   = 313;
  localparam int BIT_FRAME     = 314;
  localparam int CNT_LSB       = 315;
  localparam int CNT_MSB       = 319;
  localparam logic [TO_MSB:TO_LSB] TO_RST = 24'h000000;

  // first byte of a received data link packet
  localparam logic [4:0] PM_HI      = 5'h04;   // 0010_0xxx power-management group
  localparam logic [3:0] FC_INIT1_P = 4'h4;
  localparam logic [3:0] FC_INIT1_C = 4'h6;
  localparam logic [3:0] FC_INIT2_P = 4'hC;
  localparam logic [3:0] FC_INIT2_C = 4'hE;
  localparam logic [3:0] FC_UPD_P   = 4'h8;
  localparam logic [3:0] FC_UPD_C   = 4'hA;
  localparam logic [2:0] CHAN_RST   = 3'h0;
  localparam logic [3:0] KIND_RST   = 4'h0;

  typedef enum logic [1:0] {AN_IDLE, AN_ACK, AN_NAK} drd_acknak_t;

endpackage

// >>> drd_seq_class.sv
`timescale 1ns/1ns
// sorts one received packet end into exactly one outcome
module drd_seq_class (
  input  wire logic                      tlp_end_i,
  input  wire logic                      nullified_i,
  input  wire logic                      lcrc_ok_i,
  input  wire logic [drd_pkg::SEQ_W-1:0] seq_i,
  input  wire logic [drd_pkg::SEQ_W-1:0] expect_i,
  output logic                           null_o,
  output logic                           crc_bad_o,
  output logic                           valid_o,
  output logic                           dup_o,
  output logic                           oos_o
);

  logic [drd_pkg::SEQ_W-1:0] behind;
  logic                      good;
  logic                      eq_seq;
  logic                      in_past;

  // distance modulo the sequence space; half the space back counts as already seen
  always_comb begin
    behind  = expect_i - seq_i;
    good    = tlp_end_i && !nullified_i && lcrc_ok_i;
    eq_seq  = (behind == '0);
    in_past = !eq_seq && (behind <= drd_pkg::SEQ_HALF);
    null_o    = tlp_end_i && nullified_i;
    crc_bad_o = tlp_end_i && !nullified_i && !lcrc_ok_i;
    valid_o   = good && eq_seq;
    dup_o     = good && in_past;
    oos_o     = good && !eq_seq && !in_past;
  end

endmodule

// >>> drd_status.sv
`timescale 1ns/1ns
module drd_status (
  input  wire logic                              SYS_CLK_I,
  input  wire logic                              RSTN_I,
  input  wire logic                              CE_I,
  input  wire logic                              TLP_END_I,
  input  wire logic                              TLP_NULL_I,
  input  wire logic                              TLP_LCRC_OK_I,
  input  wire logic [drd_pkg::SEQ_W-1:0]         TLP_SEQ_I,
  input  wire logic                              DLLP_VALID_I,
  input  wire logic [7:0]                        DLLP_BYTE0_I,
  input  wire logic                              FRAME_BAD_I,
  input  wire logic                              ACKNAK_SENT_I,
  input  wire logic                              RETRY_PUSH_I,
  input  wire logic                              RETRY_POP_I,
  output logic [drd_pkg::TO_MSB:drd_pkg::TO_LSB] TEST_OUT_O,
  output logic                                   TLP_FWD_O,
  output logic                                   TLP_DROP_O,
  output logic                                   RX_PORT_ERR_O,
  output logic                                   RETRAIN_REQ_O,
  output logic                                   ACKNAK_REQ_O,
  output logic                                   ACKNAK_NAK_O,
  output logic [drd_pkg::SEQ_W-1:0]              ACKNAK_SEQ_O
);

  // saturating step of an occupancy counter
  function automatic logic [drd_pkg::RCNT_W-1:0] cnt_step(input logic [drd_pkg::RCNT_W-1:0] c,
                                                          input logic up, input logic dn);
    cnt_step = c;
    if (up && !dn && c != drd_pkg::RCNT_MAX) begin
      cnt_step = c + drd_pkg::RCNT_W'(1);
    end else if (dn && !up && c != drd_pkg::RCNT_RST) begin
      cnt_step = c - drd_pkg::RCNT_W'(1);
    end
  endfunction

  // credit packet kind test on the upper nibble of byte 0
  function automatic logic is_credit(input logic [7:0] b);
    logic [3:0] k;
    k = b[7:4];
    is_credit = !b[3] && ((k >= drd_pkg::FC_INIT1_P && k <= drd_pkg::FC_INIT1_C) ||
                          (k >= drd_pkg::FC_INIT2_P && k <= drd_pkg::FC_INIT2_C) ||
                          (k >= drd_pkg::FC_UPD_P   && k <= drd_pkg::FC_UPD_C));
  endfunction

  logic c_null;
  logic c_crc;
  logic c_valid;
  logic c_dup;
  logic c_oos;

  logic [drd_pkg::SEQ_W-1:0] expect_r;
  logic [drd_pkg::SEQ_W-1:0] expect_nxt;

  drd_seq_class u_class (
    .tlp_end_i   (TLP_END_I),
    .nullified_i (TLP_NULL_I),
    .lcrc_ok_i   (TLP_LCRC_OK_I),
    .seq_i       (TLP_SEQ_I),
    .expect_i    (expect_r),
    .null_o      (c_null),
    .crc_bad_o   (c_crc),
    .valid_o     (c_valid),
    .dup_o       (c_dup),
    .oos_o       (c_oos)
  );

  // ---- acknowledgement scheduling state
  drd_pkg::drd_acknak_t       an_r;
  drd_pkg::drd_acknak_t       an_nxt;
  logic                       lat_run_r;
  logic                       lat_run_nxt;
  logic [drd_pkg::LAT_W-1:0]  lat_cnt_r;
  logic [drd_pkg::LAT_W-1:0]  lat_cnt_nxt;
  logic                       lat_exp;
  logic                       nak_block_r;
  logic                       nak_block_nxt;
  logic                       want_nak;
  logic                       want_ack;

  // next expected sequence advances only on an in-order good packet
  always_comb begin
    expect_nxt = expect_r;
    if (c_valid) begin
      expect_nxt = expect_r + drd_pkg::SEQ_ONE;
    end
  end

  // latency timer and ack/nak pending state; a new schedule wins over a same-cycle sent
  always_comb begin
    lat_run_nxt   = lat_run_r;
    lat_cnt_nxt   = lat_cnt_r;
    an_nxt        = an_r;
    nak_block_nxt = nak_block_r;
    lat_exp       = lat_run_r && (lat_cnt_r == drd_pkg::LAT_LAST);
    // one nak per error episode; a good in-order packet re-arms it
    want_nak      = (c_crc || c_oos) && !nak_block_r;
    want_ack      = lat_exp || c_dup;
    if (lat_run_r) begin
      lat_cnt_nxt = lat_cnt_r + drd_pkg::LAT_W'(1);
    end
    if (lat_exp) begin
      lat_run_nxt = 1'b0;
      lat_cnt_nxt = drd_pkg::LAT_RST;
    end else if (c_valid && !lat_run_r) begin
      lat_run_nxt = 1'b1;
      lat_cnt_nxt = drd_pkg::LAT_RST;
    end
    if (c_valid) begin
      nak_block_nxt = 1'b0;
    end
    if (ACKNAK_SENT_I) begin
      an_nxt = drd_pkg::AN_IDLE;
    end
    if (want_nak) begin
      an_nxt        = drd_pkg::AN_NAK;
      nak_block_nxt = 1'b1;
      lat_run_nxt   = 1'b0;
      lat_cnt_nxt   = drd_pkg::LAT_RST;
    end else if (want_ack && !(an_r == drd_pkg::AN_NAK && !ACKNAK_SENT_I)) begin
      an_nxt = drd_pkg::AN_ACK;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      expect_r    <= drd_pkg::SEQ_RST;
      an_r        <= drd_pkg::AN_IDLE;
      lat_run_r   <= 1'b0;
      lat_cnt_r   <= drd_pkg::LAT_RST;
      nak_block_r <= 1'b0;
    end else if (CE_I) begin
      expect_r    <= expect_nxt;
      an_r        <= an_nxt;
      lat_run_r   <= lat_run_nxt;
      lat_cnt_r   <= lat_cnt_nxt;
      nak_block_r <= nak_block_nxt;
    end
  end

  // ---- retry buffer occupancy
  logic [drd_pkg::RCNT_W-1:0] rcnt_r;
  logic [drd_pkg::RCNT_W-1:0] rcnt_nxt;
  logic [4:0]                 rcnt_view;

  // internal count is wide so the view stays honest after draining from above 31
  always_comb begin
    rcnt_nxt  = cnt_step(rcnt_r, RETRY_PUSH_I, RETRY_POP_I);
    rcnt_view = (rcnt_nxt > drd_pkg::RCNT_W'(drd_pkg::RCNT_SAT)) ? drd_pkg::RCNT_SAT
                                                                  : rcnt_nxt[4:0];
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rcnt_r <= drd_pkg::RCNT_RST;
    end else if (CE_I) begin
      rcnt_r <= rcnt_nxt;
    end
  end

  // ---- received data link packet decode and test-output image
  logic [drd_pkg::TO_MSB:drd_pkg::TO_LSB] to_r;
  logic [drd_pkg::TO_MSB:drd_pkg::TO_LSB] to_nxt;
  logic                                   pm_rx;
  logic                                   fc_rx;
  logic                                   fwd_r;
  logic                                   fwd_nxt;
  logic                                   drop_r;
  logic                                   drop_nxt;
  logic                                   perr_r;
  logic                                   perr_nxt;
  logic [drd_pkg::SEQ_W-1:0]              an_seq_r;
  logic [drd_pkg::SEQ_W-1:0]              an_seq_nxt;

  // kind and channel fields hold the last received value between packets
  always_comb begin
    pm_rx  = DLLP_VALID_I && (DLLP_BYTE0_I[7:3] == drd_pkg::PM_HI);
    fc_rx  = DLLP_VALID_I && is_credit(DLLP_BYTE0_I);
    to_nxt = to_r;
    to_nxt[drd_pkg::BIT_LAT_RUN]   = lat_run_nxt;
    to_nxt[drd_pkg::BIT_LAT_EXP]   = lat_exp;
    to_nxt[drd_pkg::BIT_AN_REQ]    = (an_nxt != drd_pkg::AN_IDLE);
    to_nxt[drd_pkg::BIT_AN_NAK]    = (an_nxt == drd_pkg::AN_NAK);
    to_nxt[drd_pkg::BIT_PM_RX]     = pm_rx;
    to_nxt[drd_pkg::BIT_FC_RX]     = fc_rx;
    if (pm_rx) begin
      to_nxt[drd_pkg::FC_CHAN_MSB:drd_pkg::FC_CHAN_LSB] = DLLP_BYTE0_I[2:0];
    end
    if (fc_rx) begin
      to_nxt[drd_pkg::FC_KIND_MSB:drd_pkg::FC_KIND_LSB] = DLLP_BYTE0_I[7:4];
      to_nxt[drd_pkg::FC_CHAN_MSB:drd_pkg::FC_CHAN_LSB] = DLLP_BYTE0_I[2:0];
    end
    to_nxt[drd_pkg::BIT_TLP_NULL]  = c_null;
    to_nxt[drd_pkg::BIT_TLP_CRC]   = c_crc;
    to_nxt[drd_pkg::BIT_TLP_VALID] = c_valid;
    to_nxt[drd_pkg::BIT_TLP_DUP]   = c_dup;
    to_nxt[drd_pkg::BIT_TLP_OOS]   = c_oos;
    to_nxt[drd_pkg::BIT_FRAME]     = FRAME_BAD_I;
    to_nxt[drd_pkg::CNT_MSB:drd_pkg::CNT_LSB] = rcnt_view;
    fwd_nxt    = c_valid;
    drop_nxt   = c_dup;
    perr_nxt   = FRAME_BAD_I;
    // ack/nak carries the last good sequence, one below the next expected
    an_seq_nxt = expect_nxt - drd_pkg::SEQ_ONE;
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      to_r     <= drd_pkg::TO_RST;
      fwd_r    <= 1'b0;
      drop_r   <= 1'b0;
      perr_r   <= 1'b0;
      an_seq_r <= drd_pkg::SEQ_RST - drd_pkg::SEQ_ONE;
    end else if (CE_I) begin
      to_r     <= to_nxt;
      fwd_r    <= fwd_nxt;
      drop_r   <= drop_nxt;
      perr_r   <= perr_nxt;
      an_seq_r <= an_seq_nxt;
    end
  end

  // all data outputs come straight from flip-flops
  assign TEST_OUT_O    = to_r;
  assign TLP_FWD_O     = fwd_r;
  assign TLP_DROP_O    = drop_r;
  assign RX_PORT_ERR_O = perr_r;
  assign RETRAIN_REQ_O = perr_r;
  assign ACKNAK_REQ_O  = to_r[drd_pkg::BIT_AN_REQ];
  assign ACKNAK_NAK_O  = to_r[drd_pkg::BIT_AN_NAK];
  assign ACKNAK_SEQ_O  = an_seq_r;

endmodule

// >>> drd_status_properties.sv
`timescale 1ns/1ns
// relations between the strobes and the debug slice, seen at the top ports only
module drd_status_chk (
  input wire logic         SYS_CLK_I,
  input wire logic         RSTN_I,
  input wire logic         CE_I,
  input wire logic         TLP_END_I,
  input wire logic         TLP_NULL_I,
  input wire logic         TLP_LCRC_OK_I,
  input wire logic         DLLP_VALID_I,
  input wire logic [7:0]   DLLP_BYTE0_I,
  input wire logic         FRAME_BAD_I,
  input wire logic         RETRY_PUSH_I,
  input wire logic         RETRY_POP_I,
  input wire logic [319:296] TEST_OUT_O,
  input wire logic         TLP_FWD_O,
  input wire logic         TLP_DROP_O,
  input wire logic         RX_PORT_ERR_O,
  input wire logic         RETRAIN_REQ_O,
  input wire logic         ACKNAK_REQ_O,
  input wire logic         ACKNAK_NAK_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // decoded strobes; bit3 of a credit byte must be clear
  wire logic pm_in = CE_I && DLLP_VALID_I && DLLP_BYTE0_I >= 8'h20 && DLLP_BYTE0_I <= 8'h24;
  wire logic fc_in = CE_I && DLLP_VALID_I && !DLLP_BYTE0_I[3] &&
                     (DLLP_BYTE0_I[7:4] inside {4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE});
  wire logic [4:0] cnt = TEST_OUT_O[319:315];
  null_pulse_a: assert property (CE_I && TLP_END_I && TLP_NULL_I |=> TEST_OUT_O[309])
    else $error("nullified packet not flagged");
  crc_pulse_a: assert property (CE_I && TLP_END_I && !TLP_NULL_I && !TLP_LCRC_OK_I |=> TEST_OUT_O[310])
    else $error("crc failure not flagged");
  valid_fwd_a: assert property (TEST_OUT_O[311] |-> TLP_FWD_O && $past(TLP_END_I) && $past(TLP_LCRC_OK_I))
    else $error("valid flag without good packet or forward");
  dup_drop_a: assert property (TEST_OUT_O[312] |-> TLP_DROP_O && !TLP_FWD_O)
    else $error("duplicate not dropped");
  class_onehot_a: assert property ($onehot0(TEST_OUT_O[313:311]))
    else $error("several packet classes at once");
  frame_err_a: assert property (CE_I && FRAME_BAD_I |=> TEST_OUT_O[314] && RX_PORT_ERR_O && RETRAIN_REQ_O)
    else $error("framing error not reported");
  power_kind_a: assert property (pm_in |=> TEST_OUT_O[300] && TEST_OUT_O[308:306] == $past(DLLP_BYTE0_I[2:0]))
    else $error("power packet kind wrong");
  credit_info_a: assert property (fc_in |=> TEST_OUT_O[301] && TEST_OUT_O[305:302] == $past(DLLP_BYTE0_I[7:4]) &&
                                   TEST_OUT_O[308:306] == $past(DLLP_BYTE0_I[2:0]))
    else $error("credit packet fields wrong");
  expiry_ack_a: assert property (TEST_OUT_O[297] |-> $past(TEST_OUT_O[296]) && !TEST_OUT_O[296] &&
                                  TEST_OUT_O[298] && !TEST_OUT_O[299])
    else $error("expiry did not schedule an ack");
  timer_span_a: assert property ($rose(TEST_OUT_O[296]) |-> ##[1:100] !TEST_OUT_O[296])
    else $error("latency timer ran too long");
  pending_pins_a: assert property (ACKNAK_REQ_O == TEST_OUT_O[298] && ACKNAK_NAK_O == TEST_OUT_O[299])
    else $error("ack/nak pins disagree with slice");
  count_step_a: assert property (cnt != $past(cnt) |-> $past(CE_I) && $past(RETRY_PUSH_I) != $past(RETRY_POP_I))
    else $error("retry count moved without push or pop");
  cover property (TEST_OUT_O[297]);
  cover property (TEST_OUT_O[313] && TEST_OUT_O[299]);
  cover property (cnt == 5'h1F);
endmodule
bind drd_status drd_status_chk i_chk (.*);

// >>> drd_monitor.sv
`timescale 1ns/1ns
// debug monitor on the slice; samples every rising clock edge so single-cycle pulses are never missed
module drd_monitor (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [23:0] probe_i,
  output logic [7:0]       valid_seen_o
);
  logic [7:0] valid_seen_r;
  logic [7:0] valid_seen_nxt;
  // counts forwarded-packet pulses, bit 311 of the slice
  always_comb begin
    valid_seen_nxt = valid_seen_r + {7'h00, probe_i[15]};
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) valid_seen_r <= 8'h00;
    else valid_seen_r <= valid_seen_nxt;
  end
  assign valid_seen_o = valid_seen_r;
endmodule

// >>> drd_status_tb_top.sv
`timescale 1ns/1ns
module drd_status_tb_top;
  typedef struct {logic [7:0] b; logic pm; logic fc; logic [3:0] kind;} drd_row_t;
  logic        sys_clk, rstn, ce, tlp_end, tlp_null, lcrc_ok, dllp_valid, frame_bad, sent, push, pop;
  logic [11:0] seq, an_seq;
  logic [7:0]  dllp_b0, mon_cnt;
  logic [23:0] test_out;
  logic        fwd, drop, perr, rtrn, an_req, an_nak;
  int          miscompares = 0, samples_checked = 0, cycles = 0, n;
  drd_row_t    rows [9] = '{'{8'h20, 1, 0, 4'h0}, '{8'h21, 1, 0, 4'h0}, '{8'h23, 1, 0, 4'h0},
                             '{8'h24, 1, 0, 4'h0}, '{8'h40, 0, 1, 4'h4}, '{8'hC7, 0, 1, 4'hC},
                             '{8'h83, 0, 1, 4'h8}, '{8'h91, 0, 1, 4'h9}, '{8'hA5, 0, 1, 4'hA}};

  drd_status i_dut (.SYS_CLK_I(sys_clk), .RSTN_I(rstn), .CE_I(ce), .TLP_END_I(tlp_end), .TLP_NULL_I(tlp_null),
    .TLP_LCRC_OK_I(lcrc_ok), .TLP_SEQ_I(seq), .DLLP_VALID_I(dllp_valid), .DLLP_BYTE0_I(dllp_b0),
    .FRAME_BAD_I(frame_bad), .ACKNAK_SENT_I(sent), .RETRY_PUSH_I(push), .RETRY_POP_I(pop),
    .TEST_OUT_O(test_out), .TLP_FWD_O(fwd), .TLP_DROP_O(drop), .RX_PORT_ERR_O(perr), .RETRAIN_REQ_O(rtrn),
    .ACKNAK_REQ_O(an_req), .ACKNAK_NAK_O(an_nak), .ACKNAK_SEQ_O(an_seq));
  drd_monitor i_mon (.clk_i(sys_clk), .rstn_i(rstn), .probe_i(test_out), .valid_seen_o(mon_cnt));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // strobe held by the caller so back-to-back packets never re-assign it
  task automatic pkt(logic nul, logic ok, logic [11:0] s);
    tlp_null = nul;
    lcrc_ok = ok;
    seq = s;
    @(negedge sys_clk);
  endtask

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    {tlp_end, tlp_null, lcrc_ok, dllp_valid, frame_bad, sent, push, pop} = 8'h00;
    {rstn, ce, seq, dllp_b0} = {2'b01, 12'h000, 8'h00};
    repeat (5) @(negedge sys_clk);
    check("reset_slice", test_out, 24'h000000);
    check("reset_seq", 24'(an_seq), 24'h000FFF);
    rstn = 1'b1;
    // with the clock enable low an event is lost
    ce = 1'b0;
    frame_bad = 1'b1;
    @(negedge sys_clk);
    {ce, frame_bad} = 2'b10;
    @(negedge sys_clk);
    check("frame_ce_off", 24'(test_out[18]), 24'h0);
    // received data link packets, back to back
    dllp_valid = 1'b1;
    foreach (rows[i]) begin
      dllp_b0 = rows[i].b;
      @(negedge sys_clk);
      check("power_flag", 24'(test_out[4]), 24'(rows[i].pm));
      check("credit_flag", 24'(test_out[5]), 24'(rows[i].fc));
      check("channel", 24'(test_out[12:10]), 24'(rows[i].b[2:0]));
      if (rows[i].fc) check("credit_kind", 24'(test_out[9:6]), 24'(rows[i].kind));
    end
    dllp_valid = 1'b0;
    // first good packet starts the latency timer
    tlp_end = 1'b1;
    pkt(1'b0, 1'b1, 12'h000);
    tlp_end = 1'b0;
    check("fwd_first", {22'h0, test_out[15], fwd}, 24'h3);
    check("timer_run", 24'(test_out[0]), 24'h1);
    n = 0;
    while (test_out[1] !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    check("lat_cycles", 24'(n), 24'd100);
    check("ack_pending", 24'(test_out[3:2]), 24'h1);
    check("ack_pins", {22'h0, an_nak, an_req}, 24'h1);
    sent = 1'b1;
    @(negedge sys_clk);
    sent = 1'b0;
    check("ack_sent", 24'(test_out[2]), 24'h0);
    // valid, duplicate, ahead, crc error, nullified in consecutive cycles
    tlp_end = 1'b1;
    pkt(1'b0, 1'b1, 12'h001);
    check("valid_cls", {19'h0, fwd, drop, test_out[17:15]}, 24'h11);
    check("next_seq", 24'(an_seq), 24'h1);
    pkt(1'b0, 1'b1, 12'h001);
    check("dup_cls", {19'h0, fwd, drop, test_out[17:15]}, 24'h0A);
    pkt(1'b0, 1'b1, 12'h005);
    check("oos_cls", {19'h0, fwd, drop, test_out[17:15]}, 24'h04);
    check("nak_pending", 24'(test_out[3:2]), 24'h3);
    pkt(1'b0, 1'b0, 12'h002);
    check("crc_flag", 24'(test_out[14]), 24'h1);
    pkt(1'b1, 1'b0, 12'h002);
    tlp_end = 1'b0;
    check("null_flag", 24'(test_out[13]), 24'h1);
    check("mon_valid", 24'(mon_cnt), 24'h2);
    // framing error
    frame_bad = 1'b1;
    @(negedge sys_clk);
    frame_bad = 1'b0;
    check("frame_err", {21'h0, test_out[18], perr, rtrn}, 24'h7);
    // retry count saturates, cancels on push with pop, then drains
    push = 1'b1;
    repeat (33) @(negedge sys_clk);
    check("cnt_sat", 24'(test_out[23:19]), 24'd31);
    pop = 1'b1;
    @(negedge sys_clk);
    push = 1'b0;
    check("cnt_cancel", 24'(test_out[23:19]), 24'd31);
    repeat (3) @(negedge sys_clk);
    pop = 1'b0;
    check("cnt_drain", 24'(test_out[23:19]), 24'd30);
    // reset in mid-run
    rstn = 1'b0;
    @(negedge sys_clk);
    check("rerst_slice", test_out, 24'h000000);
    check("rerst_seq", 24'(an_seq), 24'h000FFF);
    rstn = 1'b1;
    // first edge after a second release must not show stale events
    @(negedge sys_clk);
    check("post_rerst_slice", test_out, 24'h000000);
    check("post_rerst_seq", 24'(an_seq), 24'h000FFF);
    complete_run();
  end
endmodule
